// file: tsr_pkg.sv
// Package for the temperature result register block: command codes, field layout, types.
// Assumes an SMBus slave front end that decodes command and data bytes elsewhere.
package tsr_pkg;
	localparam int TSR_DW = 8;
	localparam logic [7:0] TSR_CMD_READING = 8'h00;
	localparam logic [7:0] TSR_CMD_SETUP = 8'h01;
	localparam int TSR_STANDBY_BIT = 7;
	localparam int TSR_READY_BIT = 6;
	localparam logic [7:0] TSR_RESULT_RST = 8'h00;
	localparam logic [7:0] TSR_SETUP_RST = 8'h00;
	localparam logic [7:0] TSR_POS_MAX = 8'h7f;
	localparam logic [7:0] TSR_NEG_MIN = 8'h80;
	// Converter sample: signed quarter degrees, 12 bits
	localparam int TSR_SAMPLE_W = 12;
	localparam int TSR_FRAC_W = 2;

	typedef struct packed {
		logic [7:0] reading;
		logic standby;
		logic ready;
		logic [7:0] cmd;
		logic busy_seen;
		logic [11:0] pend;
		logic pend_vld;
		logic [7:0] rdata;
	} tsr_state_t;

	typedef struct packed {
		logic cmd_we;
		logic [7:0] cmd;
		logic data_we;
		logic data_re;
		logic [7:0] wdata;
		logic busy;
	} tsr_host_t;
endpackage : tsr_pkg

// file: tsr_regs.sv
// Temperature result and setup registers behind an SMBus command/data byte interface.
// Assumes a serial slave front end that strobes command, write and read bytes,
// and a converter that delivers signed quarter-degree samples with a done pulse.
// Functional notes
// [R1] Result byte holds latest conversion, read-only
// [R2] One count per degree, zero reads 0x00
// [R3] Two's complement, sign in bit seven
// [R4] Clamp high readings to 0x7f
// [R5] Round halves: up positive, toward zero negative
// [R6] All registers eight bits wide
// [R7] Reset clears result and setup to zero
// [R8] Result loads as ready flag rises
// [R9] Refresh automatically after each conversion (conversions arriving in standby are dropped)
// [R10] Command 0 selects result, 1 setup
// [R11] Setup: bit7 standby, bit6 ready, rest zero
// [R12] Ready cleared at reset and on standby
// [R13] Result never changes during a host access
`timescale 1ns/1ps
module tsr_regs #(
	parameter int SAMPLE_W = 12
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire tsr_pkg::tsr_host_t host,
	output logic [7:0] rdata,
	output logic standby,
	input wire logic conv_done,
	input wire logic [SAMPLE_W-1:0] conv_sample
);
	import tsr_pkg::*;

	// Clamp limits at sample width so that the compares stay signed
	localparam logic signed [SAMPLE_W-1:0] MAX_DEG = SAMPLE_W'(signed'(TSR_POS_MAX));
	localparam logic signed [SAMPLE_W-1:0] MIN_DEG = SAMPLE_W'(signed'(TSR_NEG_MIN));

	tsr_state_t s_q;
	tsr_state_t s_d;
	logic load_now;

	// Command decode, shared by the read path, the write path and the checks
	function automatic logic is_reading(input logic [7:0] code);
		is_reading = (code == TSR_CMD_READING);
	endfunction : is_reading

	function automatic logic is_setup(input logic [7:0] code);
		is_setup = (code == TSR_CMD_SETUP);
	endfunction : is_setup

	// Setup image; reserved bits are tied low here and nowhere else
	function automatic logic [7:0] setup_byte(input logic sb, input logic rdy);
		setup_byte = 8'h00;
		setup_byte[TSR_STANDBY_BIT] = sb; // [R11]
		setup_byte[TSR_READY_BIT] = rdy;
	endfunction : setup_byte

	// Floor plus one when the fraction is a half or more: -0.5 reads 0,
	// -0.75 reads -1, +0.5 reads 1; out-of-range readings saturate, never wrap
	function automatic logic [7:0] to_degrees(input logic [SAMPLE_W-1:0] smp);
		logic signed [SAMPLE_W-1:0] whole;
		logic [TSR_FRAC_W-1:0] fr;
		whole = signed'(smp) >>> TSR_FRAC_W;
		fr = smp[TSR_FRAC_W-1:0];
		if (fr[TSR_FRAC_W-1]) begin
			whole = whole + SAMPLE_W'(1); // [R5]
		end
		if (whole > MAX_DEG) begin
			to_degrees = TSR_POS_MAX; // [R4]
		end else if (whole < MIN_DEG) begin
			to_degrees = TSR_NEG_MIN;
		end else begin
			to_degrees = whole[7:0]; // [R2] [R3]
		end
	endfunction : to_degrees

	always_comb begin
		s_d = s_q;
		s_d.busy_seen = host.busy;
		if (host.cmd_we) begin
			s_d.cmd = host.cmd; // [R10]
		end
		// Only the standby switch takes writes; ready and reserved bits ignore them
		if (host.data_we && is_setup(s_q.cmd)) begin
			s_d.standby = host.wdata[TSR_STANDBY_BIT]; // [R11]
		end
		// A finished conversion is parked while the host is mid-access
		if (conv_done && !s_d.standby) begin
			s_d.pend = conv_sample; // [R9]
			s_d.pend_vld = 1'b1;
		end
		// Loading only on an idle bus keeps a byte being shifted out whole
		if (s_q.pend_vld && !host.busy && !s_d.standby) begin
			s_d.reading = to_degrees(s_q.pend); // [R1] [R8] [R13]
			s_d.ready = 1'b1; // [R8]
			s_d.pend_vld = conv_done;
		end
		if (s_d.standby) begin
			s_d.ready = 1'b0; // [R12]
			s_d.pend_vld = 1'b0;
		end
		// The read byte is captured once per strobe and then stands
		if (host.data_re) begin
			if (is_reading(s_q.cmd)) begin
				s_d.rdata = s_q.reading; // [R10]
			end else if (is_setup(s_q.cmd)) begin
				s_d.rdata = setup_byte(s_q.standby, s_q.ready); // [R11] [R6]
			end else begin
				s_d.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0; // [R7] [R12]
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign standby = s_q.standby;

	// Mirror of the load condition, read by the checks only
	assign load_now = s_q.pend_vld && !host.busy && !s_d.standby;

	a_hold_busy: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
		host.busy && s_q.busy_seen
		|-> $stable(s_q.reading))
		else $error("result changed during access");

	a_ready_standby: assert property (@(posedge clk_sys) disable iff (!rstn) // [R12]
		s_q.standby
		|-> !s_q.ready)
		else $error("ready set in standby");

	a_setup_read: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
		host.data_re && is_setup(s_q.cmd)
		|=> rdata[TSR_READY_BIT-1:0] == 6'h00)
		else $error("reserved bits nonzero");

	a_reading_read: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		host.data_re && is_reading(s_q.cmd)
		|=> rdata == $past(s_q.reading))
		else $error("wrong result byte");

	a_ready_load: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		$rose(s_q.ready)
		|-> $past(s_q.pend_vld))
		else $error("ready rose without load");

	a_standby_write: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
		host.data_we && is_setup(s_q.cmd)
		|=> s_q.standby == $past(host.wdata[TSR_STANDBY_BIT]))
		else $error("standby not written");

	a_ro_reading: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		host.data_we && is_reading(s_q.cmd) && !s_q.pend_vld
		|=> $stable(s_q.reading))
		else $error("result written by host");

	a_auto_refresh: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
		load_now
		|=> s_q.ready)
		else $error("no refresh after conversion");

	a_reading_quiet: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		!load_now
		|=> $stable(s_q.reading))
		else $error("result changed without load");

	a_cmd_latch: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		host.cmd_we
		|=> s_q.cmd == $past(host.cmd))
		else $error("command not latched");

	a_other_read: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		host.data_re && !is_reading(s_q.cmd) && !is_setup(s_q.cmd)
		|=> rdata == 8'h00)
		else $error("unknown command read nonzero");

	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		!host.data_re
		|=> $stable(rdata))
		else $error("read byte changed without strobe");

	a_standby_drop: assert property (@(posedge clk_sys) disable iff (!rstn) // [R12]
		s_d.standby
		|=> !s_q.pend_vld)
		else $error("conversion kept in standby");

	a_ready_sticky: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		s_q.ready && !s_d.standby
		|=> s_q.ready)
		else $error("ready dropped outside standby");

	a_positive_sign: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		load_now && !s_q.pend[SAMPLE_W-1]
		|=> !s_q.reading[7])
		else $error("positive reading has sign set");

	a_negative_sign: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		load_now && s_q.pend[SAMPLE_W-1] && !(&s_q.pend[SAMPLE_W-2:TSR_FRAC_W])
		|=> s_q.reading[7])
		else $error("negative reading lost its sign");

	a_zero_reading: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
		load_now && s_q.pend == '0
		|=> s_q.reading == 8'h00)
		else $error("zero sample not read as zero");

	a_clamp_high: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		load_now && signed'(s_q.pend) >= (MAX_DEG <<< TSR_FRAC_W)
		|=> s_q.reading == TSR_POS_MAX)
		else $error("high reading not clamped");

	a_clamp_low: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		load_now && signed'(s_q.pend) < (MIN_DEG <<< TSR_FRAC_W)
		|=> s_q.reading == TSR_NEG_MIN)
		else $error("low reading not clamped");

	a_stable_setup: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
		!(host.data_we && is_setup(s_q.cmd))
		|=> $stable(s_q.standby))
		else $error("standby changed without write");

	a_pend_keep: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
		s_q.pend_vld && host.busy && !s_d.standby
		|=> s_q.pend_vld)
		else $error("parked conversion lost");
endmodule : tsr_regs

// file: tsr_conv_model.sv
// Converter stand-in: quarter-degree samples with a one-cycle done pulse.
// Assumes the bench calls send between falling edges of clk_sys.
`timescale 1ns/1ps
module tsr_conv_model (
	input wire logic clk_sys,
	output logic conv_done,
	output logic [11:0] conv_sample
);
	initial begin
		conv_done = 1'b0;
		conv_sample = 12'ha5a;
	end
	task automatic send(input logic [11:0] s);
		@(negedge clk_sys) conv_done = 1'b1;
		conv_sample = s;
		@(negedge clk_sys) conv_done = 1'b0;
		// Stale bus is inverted so a late capture shows up
		conv_sample = ~s;
	endtask : send
endmodule : tsr_conv_model

// file: tsr_regs_tb.sv
// Bench for the result and setup registers, driven by byte strobes.
// Assumes a 20 MHz clock and strobes taken on rising edges.
`timescale 1ns/1ps
module tsr_regs_tb;
	import tsr_pkg::*;
	logic clk_sys, rstn, standby, conv_done;
	logic [7:0] rdata;
	logic [11:0] conv_sample;
	tsr_host_t host;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [11:0] smp [11] = '{12'h208, 12'h1fa, 12'h065, 12'h002, 12'h000, 12'hffe,
		12'hffd, 12'hf9c, 12'hf25, 12'hefc, 12'hd00};
	logic [7:0] res [11] = '{8'h7f, 8'h7f, 8'h19, 8'h01, 8'h00, 8'h00,
		8'hff, 8'he7, 8'hc9, 8'hbf, 8'h80};
	tsr_regs dut (.clk_sys(clk_sys), .rstn(rstn), .host(host), .rdata(rdata),
		.standby(standby), .conv_done(conv_done), .conv_sample(conv_sample));
	tsr_conv_model cm (.clk_sys(clk_sys), .conv_done(conv_done), .conv_sample(conv_sample));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic close_out;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic sel(input logic [7:0] c);
		@(negedge clk_sys) host.cmd_we = 1'b1;
		host.cmd = c;
		@(negedge clk_sys) host.cmd_we = 1'b0;
	endtask : sel
	task automatic rd(input logic [7:0] c, input logic [7:0] exp);
		sel(c);
		host.data_re = 1'b1;
		@(negedge clk_sys) host.data_re = 1'b0;
		chk(rdata, exp);
	endtask : rd
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		sel(c);
		host.data_we = 1'b1;
		host.wdata = d;
		@(negedge clk_sys) host.data_we = 1'b0;
	endtask : wr
	initial begin
		host = '0;
		rstn = 1'b0;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		rd(TSR_CMD_READING, TSR_RESULT_RST);
		rd(TSR_CMD_SETUP, TSR_SETUP_RST);
		for (int i = 0; i < 11; i++) begin
			cm.send(smp[i]);
			rd(TSR_CMD_READING, res[i]);
		end
		rd(TSR_CMD_SETUP, 8'h40);
		wr(TSR_CMD_READING, 8'h55);
		rd(8'h02, 8'h00);
		rd(TSR_CMD_READING, 8'h80);
		host.busy = 1'b1;
		cm.send(12'h064);
		rd(TSR_CMD_READING, 8'h80);
		host.busy = 1'b0;
		repeat (2) @(negedge clk_sys);
		rd(TSR_CMD_READING, 8'h19);
		wr(TSR_CMD_SETUP, 8'hff);
		rd(TSR_CMD_SETUP, 8'h80);
		chk({7'h00, standby}, 8'h01);
		cm.send(12'h000);
		rd(TSR_CMD_READING, 8'h19);
		wr(TSR_CMD_SETUP, 8'h00);
		chk({7'h00, standby}, 8'h00);
		cm.send(12'h018);
		rd(TSR_CMD_READING, 8'h06);
		rd(TSR_CMD_SETUP, 8'h40);
		close_out();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 500) begin
			n_mismatch++;
			close_out();
		end
	end
endmodule : tsr_regs_tb
